// *** verification/bput_timer_tb.sv ***
// Self-checking testbench for the basic up-count timer and its register file.
// Assumes the design package and register header are compiled first; ce is held high.
`timescale 1ns/1ps
`default_nettype none
`include "bput_regs.svh"
module bput_timer_tb;
	import bput_pkg::*;

	// ****************************************************************
	// Signals, counters and the design instance.
	// ****************************************************************
	localparam int TIMEOUT_CYC = 5000;
	logic clk, reset, ce, avs_read, avs_write, avs_waitrequest;
	logic slave_reset_in, irq, dma_req, master_trigger;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int mt_cnt = 0;
	int dma_t[$];
	int n0, m0, t0, d0;

	bput_timer #(.CNT_W(16)) bput_timer_i (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.slave_reset_in(slave_reset_in),
		.irq(irq),
		.dma_req(dma_req),
		.master_trigger(master_trigger)
	);

	// ****************************************************************
	// Bus tasks, compare tasks and the closing report.
	// ****************************************************************
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic ci(input string nm, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic cr(input string nm, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] g;
		rd(a, g);
		ck(nm, e, g);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Waits until the design has raised n DMA pulses in all; the timeout bounds it.
	// One more edge lets the registered outputs that follow the event settle.
	task automatic wait_dma(input int n);
		while (dma_t.size() < n) @(posedge clk);
		@(posedge clk);
	endtask

	// Issues a software event and lets its effects settle.
	task automatic soft_ev();
		wr(`BPUT_OFS_SOFT_EVENT, 32'h00000001);
		repeat (3) @(posedge clk);
	endtask

	// ****************************************************************
	// Clock, monitor and timeout.
	// ****************************************************************
	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Stamps DMA pulses, counts trigger-high cycles and cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dma_req === 1'b1) dma_t.push_back(cyc);
		if (master_trigger === 1'b1) mt_cnt <= mt_cnt + 1;
		if (cyc >= TIMEOUT_CYC) begin
			fail_count++;
			print_verdict();
		end
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	// Resets the design, then works through the scenarios in turn.
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		slave_reset_in = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Control, enable, status and count registers, and one unmapped place, read zero after reset.
		cr("ctrl1", `BPUT_OFS_CTRL_ONE, 32'h0);
		cr("ctrl2", `BPUT_OFS_CTRL_TWO, 32'h0);
		cr("unmapped", 6'h08, 32'h0);
		cr("enables", `BPUT_OFS_DMA_IRQ_EN, 32'h0);
		cr("status", `BPUT_OFS_IRQ_STATUS, 32'h0);
		cr("count", `BPUT_OFS_COUNT_VALUE, 32'h0);
		// Overflow interval with divider 1 and period 3 is 8 clocks.
		wr(`BPUT_OFS_DIVIDER, 32'h1);
		wr(`BPUT_OFS_PERIOD, 32'h3);
		wr(`BPUT_OFS_DMA_IRQ_EN, 32'h101);
		wr(`BPUT_OFS_CTRL_TWO, 32'h10);
		cr("ctrl2", `BPUT_OFS_CTRL_TWO, 32'h10);
		n0 = dma_t.size();
		wr(`BPUT_OFS_CTRL_ONE, 32'h1);
		wait_dma(n0 + 3);
		ci("interval", 8, dma_t[n0 + 2] - dma_t[n0 + 1]);
		ck("trig enable", 32'h1, {31'h0, master_trigger});
		ck("irq on", 32'h1, {31'h0, irq});
		wr(`BPUT_OFS_CTRL_ONE, 32'h0);
		// The flag ignores a written one, gates irq with its enable, clears on zero.
		cr("flag set", `BPUT_OFS_IRQ_STATUS, 32'h1);
		wr(`BPUT_OFS_IRQ_STATUS, 32'h1);
		cr("flag w1", `BPUT_OFS_IRQ_STATUS, 32'h1);
		// The interrupt output lags its enable by one registered cycle.
		wr(`BPUT_OFS_DMA_IRQ_EN, 32'h100);
		@(posedge clk);
		ck("irq masked", 32'h0, {31'h0, irq});
		wr(`BPUT_OFS_DMA_IRQ_EN, 32'h101);
		@(posedge clk);
		ck("irq again", 32'h1, {31'h0, irq});
		wr(`BPUT_OFS_IRQ_STATUS, 32'h0);
		cr("flag w0", `BPUT_OFS_IRQ_STATUS, 32'h0);
		ck("irq clear", 32'h0, {31'h0, irq});
		ck("trig stop", 32'h0, {31'h0, master_trigger});
		// A software event reinitialises the count, sets the flag, pulses DMA and update.
		wr(`BPUT_OFS_CTRL_TWO, 32'h20);
		wr(`BPUT_OFS_COUNT_VALUE, 32'h5);
		cr("count wr", `BPUT_OFS_COUNT_VALUE, 32'h5);
		n0 = dma_t.size();
		m0 = mt_cnt;
		soft_ev();
		cr("reinit", `BPUT_OFS_COUNT_VALUE, 32'h0);
		cr("soft flag", `BPUT_OFS_IRQ_STATUS, 32'h1);
		ci("dma", 1, dma_t.size() - n0);
		ci("trig update", 1, mt_cnt - m0);
		cr("soft reads", `BPUT_OFS_SOFT_EVENT, 32'h0);
		wr(`BPUT_OFS_IRQ_STATUS, 32'h0);
		wr(`BPUT_OFS_SOFT_EVENT, 32'h0);
		repeat (3) @(posedge clk);
		cr("soft zero", `BPUT_OFS_IRQ_STATUS, 32'h0);
		wr(`BPUT_OFS_CTRL_TWO, 32'h0);
		m0 = mt_cnt;
		soft_ev();
		ci("trig reset", 1, mt_cnt - m0);
		// Source select and inhibit each keep the flag and DMA quiet.
		for (int i = 0; i < 2; i++) begin
			wr(`BPUT_OFS_IRQ_STATUS, 32'h0);
			wr(`BPUT_OFS_CTRL_ONE, i == 0 ? 32'h4 : 32'h2);
			wr(`BPUT_OFS_COUNT_VALUE, 32'h9);
			n0 = dma_t.size();
			soft_ev();
			cr("count", `BPUT_OFS_COUNT_VALUE, 32'h0);
			cr("no flag", `BPUT_OFS_IRQ_STATUS, 32'h0);
			ci("no dma", 0, dma_t.size() - n0);
		end
		// A running counter with inhibit set wraps several times without any event.
		wr(`BPUT_OFS_IRQ_STATUS, 32'h0);
		n0 = dma_t.size();
		wr(`BPUT_OFS_CTRL_ONE, 32'h3);
		repeat (40) @(posedge clk);
		wr(`BPUT_OFS_CTRL_ONE, 32'h2);
		cr("inhibit flag", `BPUT_OFS_IRQ_STATUS, 32'h0);
		ci("inhibit dma", 0, dma_t.size() - n0);
		// With DMA disabled an event still sets the flag but raises no request.
		wr(`BPUT_OFS_CTRL_ONE, 32'h0);
		wr(`BPUT_OFS_DMA_IRQ_EN, 32'h1);
		n0 = dma_t.size();
		soft_ev();
		cr("flag", `BPUT_OFS_IRQ_STATUS, 32'h1);
		ci("dma off", 0, dma_t.size() - n0);
		// A slave-controller reset reinitialises the count and sets the flag.
		wr(`BPUT_OFS_IRQ_STATUS, 32'h0);
		wr(`BPUT_OFS_COUNT_VALUE, 32'h7);
		slave_reset_in <= 1'b1;
		repeat (4) @(posedge clk);
		slave_reset_in <= 1'b0;
		repeat (2) @(posedge clk);
		cr("slave count", `BPUT_OFS_COUNT_VALUE, 32'h0);
		cr("slave flag", `BPUT_OFS_IRQ_STATUS, 32'h1);
		// Buffered period delays the new value by one overflow; first run is the baseline.
		wr(`BPUT_OFS_DMA_IRQ_EN, 32'h101);
		wr(`BPUT_OFS_DIVIDER, 32'h0);
		wr(`BPUT_OFS_PERIOD, 32'h1);
		wr(`BPUT_OFS_COUNT_VALUE, 32'h0);
		n0 = dma_t.size();
		wr(`BPUT_OFS_CTRL_ONE, 32'h1);
		t0 = cyc;
		wait_dma(n0 + 1);
		d0 = dma_t[n0] - t0;
		wr(`BPUT_OFS_CTRL_ONE, 32'h0);
		wr(`BPUT_OFS_PERIOD, 32'h3);
		wr(`BPUT_OFS_CTRL_ONE, 32'h80);
		wr(`BPUT_OFS_PERIOD, 32'h1);
		wr(`BPUT_OFS_COUNT_VALUE, 32'h0);
		n0 = dma_t.size();
		wr(`BPUT_OFS_CTRL_ONE, 32'h81);
		t0 = cyc;
		wait_dma(n0 + 2);
		ci("old period", 2, dma_t[n0] - t0 - d0);
		ci("new period", 2, dma_t[n0 + 1] - dma_t[n0]);
		// One-cycle mode clears the run bit at the overflow and leaves the count at zero.
		wr(`BPUT_OFS_CTRL_ONE, 32'h0);
		wr(`BPUT_OFS_PERIOD, 32'h2);
		wr(`BPUT_OFS_COUNT_VALUE, 32'h0);
		n0 = dma_t.size();
		wr(`BPUT_OFS_CTRL_ONE, 32'h9);
		wait_dma(n0 + 1);
		repeat (20) @(posedge clk);
		cr("one cycle", `BPUT_OFS_CTRL_ONE, 32'h8);
		cr("stopped", `BPUT_OFS_COUNT_VALUE, 32'h0);
		ci("one event", 1, dma_t.size() - n0);
		print_verdict();
	end
endmodule
`default_nettype wire

// *** verilog/bput_pkg.sv ***
// Types shared by the basic up-count timer modules.
// Assumes nothing of its surroundings.
package bput_pkg;

	// Master trigger output selection.
	typedef enum logic [2:0] {
		BPUT_MOS_RESET = 3'h0,
		BPUT_MOS_ENABLE = 3'h1,
		BPUT_MOS_UPDATE = 3'h2
	} bput_mos_e;

	// Bus transfer phase.
	typedef enum logic [0:0] {
		BPUT_BUS_WAIT = 1'h0,
		BPUT_BUS_ACK = 1'h1
	} bput_bus_e;

endpackage

// *** verilog/bput_prescaler.sv ***
// Prescaler that issues one tick every divider plus one enabled clocks.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module bput_prescaler #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic enable,
	input wire logic clear,
	input wire logic [CNT_W-1:0] divider,
	output logic tick
);
	logic [CNT_W-1:0] pre_r;

	// A tick marks the last clock of each divider period.
	assign tick = enable && (pre_r == divider);

	// Clear restarts the division from zero.
	always_ff @(posedge clk) begin
		if (reset) begin
			pre_r <= '0;
		end else if (ce) begin
			if (clear || tick) begin
				pre_r <= '0;
			end else if (enable) begin
				pre_r <= pre_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/bput_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the basic up-count timer.
// Assumes it is included by its bare name from files that need these constants.
`ifndef BPUT_REGS_SVH
`define BPUT_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define BPUT_OFS_CTRL_ONE 6'h00
`define BPUT_OFS_CTRL_TWO 6'h04
`define BPUT_OFS_DMA_IRQ_EN 6'h0C
`define BPUT_OFS_IRQ_STATUS 6'h10
`define BPUT_OFS_SOFT_EVENT 6'h14
`define BPUT_OFS_COUNT_VALUE 6'h24
`define BPUT_OFS_DIVIDER 6'h28
`define BPUT_OFS_PERIOD 6'h2C

// ****************************************************************
// Field positions.
// ****************************************************************
`define BPUT_BIT_TIMER_RUN 0
`define BPUT_BIT_OVF_INHIBIT 1
`define BPUT_BIT_OVF_SRC_SEL 2
`define BPUT_BIT_ONE_CYCLE 3
`define BPUT_BIT_PERIOD_BUF 7
`define BPUT_MOS_LSB 4
`define BPUT_MOS_MSB 6
`define BPUT_BIT_OVF_IRQ_ON 0
`define BPUT_BIT_OVF_DMA_ON 8
`define BPUT_BIT_OVF_FLAG 0
`define BPUT_BIT_SOFT_TRIG 0

// ****************************************************************
// Reset values.
// ****************************************************************
`define BPUT_RST_REG16 16'h0000
`define BPUT_RST_MOS 3'h0

// ****************************************************************
// Timing counts.
// ****************************************************************
`define BPUT_RUN_SYNC_CYCLES 1

`endif

// *** verilog/bput_sync2.sv ***
// Two-stage synchroniser for one level that arrives from outside the clock domain.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module bput_sync2 (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= 1'b0;
			sync_out <= 1'b0;
		end else if (ce) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** verilog/bput_timer.sv ***
// Basic 16-bit up-count timer with its register file on an Avalon-MM slave port.
// Assumes one 200 MHz clock, a synchronous active-high reset and a slave reset level from outside.
//
// Behaviour
// - Control bit 7 selects buffered period writes.
// - One-cycle bit stops counting at overflow event.
// - Source bit limits events to counter overflow.
// - Inhibit bit suppresses every overflow event.
// - Soft trigger or slave reset clears counter, prescaler.
// - Master output select picks reset, enable, update.
// - Enable bit 8 gates DMA request per event.
// - Flag set per event; write zero clears.
// - Flag also set by trigger-caused events.
// - Writing one to soft event makes event.
// - Counting enable rises one clock after run bit, falls with it.
// - Buffered period and divider load at event.
// - Count zero to period per divider plus one.
// - Counter value reads current, write replaces it.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bput_regs.svh"
module bput_timer
	import bput_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic slave_reset_in,
	output logic irq,
	output logic dma_req,
	output logic master_trigger
);
	// ****************************************************************
	// Elaboration check.
	// ****************************************************************
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
		$error("bput_timer: CNT_W must lie between 2 and 16");
	end

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic period_buffer_on_r, one_cycle_stop_r, overflow_source_sel_r, overflow_inhibit_r, timer_run_r;
	logic [2:0] master_out_select_r;
	logic overflow_dma_on_r, overflow_irq_on_r, overflow_flag_r;
	logic [CNT_W-1:0] count_r, divider_r, period_r, div_sh_r, period_sh_r;
	logic run_q_r;
	bput_bus_e bus_r;
	logic req, commit, wr_commit;
	logic slave_reset_s, slave_reset_d_r, slave_pulse;
	logic soft_trig, reinit, counting, tick, cnt_ovf, ovf_evt;
	logic [31:0] rd_nxt;

	// Decodes a byte address into a register hit.
	function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
		hit = ({addr[5:2], 2'b00} == ofs);
	endfunction

	// ****************************************************************
	// Avalon-MM slave handshake.
	// ****************************************************************
	assign req = avs_read || avs_write;
	assign commit = req && (bus_r == BPUT_BUS_ACK);
	assign wr_commit = commit && avs_write;

	// Every request waits one cycle, then is answered for exactly one cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			bus_r <= BPUT_BUS_WAIT;
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			if (req && bus_r == BPUT_BUS_WAIT) begin
				bus_r <= BPUT_BUS_ACK;
				avs_waitrequest <= 1'b0;
			end else begin
				bus_r <= BPUT_BUS_WAIT;
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// Read multiplexer; reserved bits and unmapped addresses read as zero.
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (hit(avs_address, `BPUT_OFS_CTRL_ONE)) begin
			rd_nxt[`BPUT_BIT_PERIOD_BUF] = period_buffer_on_r;
			rd_nxt[`BPUT_BIT_ONE_CYCLE] = one_cycle_stop_r;
			rd_nxt[`BPUT_BIT_OVF_SRC_SEL] = overflow_source_sel_r;
			rd_nxt[`BPUT_BIT_OVF_INHIBIT] = overflow_inhibit_r;
			rd_nxt[`BPUT_BIT_TIMER_RUN] = timer_run_r;
		end else if (hit(avs_address, `BPUT_OFS_CTRL_TWO)) begin
			rd_nxt[`BPUT_MOS_MSB:`BPUT_MOS_LSB] = master_out_select_r;
		end else if (hit(avs_address, `BPUT_OFS_DMA_IRQ_EN)) begin
			rd_nxt[`BPUT_BIT_OVF_DMA_ON] = overflow_dma_on_r;
			rd_nxt[`BPUT_BIT_OVF_IRQ_ON] = overflow_irq_on_r;
		end else if (hit(avs_address, `BPUT_OFS_IRQ_STATUS)) begin
			rd_nxt[`BPUT_BIT_OVF_FLAG] = overflow_flag_r;
		end else if (hit(avs_address, `BPUT_OFS_COUNT_VALUE)) begin
			rd_nxt[CNT_W-1:0] = count_r;
		end else if (hit(avs_address, `BPUT_OFS_DIVIDER)) begin
			rd_nxt[CNT_W-1:0] = divider_r;
		end else if (hit(avs_address, `BPUT_OFS_PERIOD)) begin
			rd_nxt[CNT_W-1:0] = period_r;
		end
	end

	// Read data is captured in the waiting cycle and stands at the answering edge.
	always_ff @(posedge clk) begin
		if (reset) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce && req && bus_r == BPUT_BUS_WAIT) begin
			avs_readdata <= avs_read ? rd_nxt : 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Event sources.
	// ****************************************************************
	bput_sync2 u_slave_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.async_in(slave_reset_in),
		.sync_out(slave_reset_s)
	);

	// Rising edge of the synchronised slave reset level.
	always_ff @(posedge clk) begin
		if (reset) begin
			slave_reset_d_r <= 1'b0;
		end else if (ce) begin
			slave_reset_d_r <= slave_reset_s;
		end
	end

	assign slave_pulse = slave_reset_s && !slave_reset_d_r;
	assign soft_trig = wr_commit && hit(avs_address, `BPUT_OFS_SOFT_EVENT)
		&& avs_writedata[`BPUT_BIT_SOFT_TRIG];
	assign reinit = soft_trig || slave_pulse;
	assign counting = run_q_r && timer_run_r && (period_sh_r != '0);
	assign cnt_ovf = counting && tick && (count_r == period_sh_r) && !reinit;
	// Inhibit blocks all sources; the source bit drops the trigger sources.
	assign ovf_evt = !overflow_inhibit_r
		&& (cnt_ovf || (!overflow_source_sel_r && reinit));

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	// Control one; a one-cycle stop at an event wins over the run bit.
	always_ff @(posedge clk) begin
		if (reset) begin
			period_buffer_on_r <= 1'b0;
			one_cycle_stop_r <= 1'b0;
			overflow_source_sel_r <= 1'b0;
			overflow_inhibit_r <= 1'b0;
			timer_run_r <= 1'b0;
		end else if (ce) begin
			if (wr_commit && hit(avs_address, `BPUT_OFS_CTRL_ONE)) begin
				period_buffer_on_r <= avs_writedata[`BPUT_BIT_PERIOD_BUF];
				one_cycle_stop_r <= avs_writedata[`BPUT_BIT_ONE_CYCLE];
				overflow_source_sel_r <= avs_writedata[`BPUT_BIT_OVF_SRC_SEL];
				overflow_inhibit_r <= avs_writedata[`BPUT_BIT_OVF_INHIBIT];
				timer_run_r <= avs_writedata[`BPUT_BIT_TIMER_RUN];
			end
			if (ovf_evt && one_cycle_stop_r) begin
				timer_run_r <= 1'b0;
			end
		end
	end

	// Control two and the DMA and interrupt enables.
	always_ff @(posedge clk) begin
		if (reset) begin
			master_out_select_r <= `BPUT_RST_MOS;
			overflow_dma_on_r <= 1'b0;
			overflow_irq_on_r <= 1'b0;
		end else if (ce && wr_commit) begin
			if (hit(avs_address, `BPUT_OFS_CTRL_TWO)) begin
				master_out_select_r <= avs_writedata[`BPUT_MOS_MSB:`BPUT_MOS_LSB];
			end
			if (hit(avs_address, `BPUT_OFS_DMA_IRQ_EN)) begin
				overflow_dma_on_r <= avs_writedata[`BPUT_BIT_OVF_DMA_ON];
				overflow_irq_on_r <= avs_writedata[`BPUT_BIT_OVF_IRQ_ON];
			end
		end
	end

	// Divider and period preload registers and their shadows.
	always_ff @(posedge clk) begin
		if (reset) begin
			divider_r <= CNT_W'(`BPUT_RST_REG16);
			period_r <= CNT_W'(`BPUT_RST_REG16);
			div_sh_r <= CNT_W'(`BPUT_RST_REG16);
			period_sh_r <= CNT_W'(`BPUT_RST_REG16);
		end else if (ce) begin
			if (wr_commit && hit(avs_address, `BPUT_OFS_DIVIDER)) begin
				divider_r <= avs_writedata[CNT_W-1:0];
			end
			if (wr_commit && hit(avs_address, `BPUT_OFS_PERIOD)) begin
				period_r <= avs_writedata[CNT_W-1:0];
			end
			if (!period_buffer_on_r || ovf_evt) begin
				div_sh_r <= divider_r;
				period_sh_r <= period_r;
			end
		end
	end

	// ****************************************************************
	// Counting.
	// ****************************************************************
	// Internal enable lags the run bit by one register stage.
	always_ff @(posedge clk) begin
		if (reset) begin
			run_q_r <= 1'b0;
		end else if (ce) begin
			run_q_r <= timer_run_r;
		end
	end

	bput_prescaler #(
		.CNT_W(CNT_W)
	) u_prescaler (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.enable(counting),
		.clear(reinit),
		.divider(div_sh_r),
		.tick(tick)
	);

	// Count up to the period, wrap to zero; trigger reinit beats a counter write.
	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= '0;
		end else if (ce) begin
			if (reinit) begin
				count_r <= '0;
			end else if (wr_commit && hit(avs_address, `BPUT_OFS_COUNT_VALUE)) begin
				count_r <= avs_writedata[CNT_W-1:0];
			end else if (cnt_ovf) begin
				count_r <= '0;
			end else if (counting && tick) begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	// ****************************************************************
	// Flag, interrupt, DMA and master trigger.
	// ****************************************************************
	// Writing zero clears the flag, but a same-cycle event keeps it set.
	always_ff @(posedge clk) begin
		if (reset) begin
			overflow_flag_r <= 1'b0;
		end else if (ce) begin
			if (ovf_evt) begin
				overflow_flag_r <= 1'b1;
			end else if (wr_commit && hit(avs_address, `BPUT_OFS_IRQ_STATUS)
				&& !avs_writedata[`BPUT_BIT_OVF_FLAG]) begin
				overflow_flag_r <= 1'b0;
			end
		end
	end

	// Registered outputs.
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
			dma_req <= 1'b0;
			master_trigger <= 1'b0;
		end else if (ce) begin
			irq <= overflow_flag_r && overflow_irq_on_r;
			dma_req <= ovf_evt && overflow_dma_on_r;
			unique case (master_out_select_r)
				BPUT_MOS_RESET: master_trigger <= reinit;
				BPUT_MOS_ENABLE: master_trigger <= counting;
				BPUT_MOS_UPDATE: master_trigger <= ovf_evt;
				default: master_trigger <= 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_RUN_LAG: assert property (ce && timer_run_r && !run_q_r && !ovf_evt |=> ##0 run_q_r)
		else $error("internal enable did not follow run bit");
	AST_ONE_CYCLE: assert property (ce && ovf_evt && one_cycle_stop_r |=> !timer_run_r && !counting)
		else $error("one-cycle mode did not stop the timer");
	AST_SRC_SEL: assert property (ce && overflow_source_sel_r && soft_trig |=> !dma_req)
		else $error("trigger raised an event with counter-only source");
	AST_INHIBIT: assert property (ce && overflow_inhibit_r && cnt_ovf |=> !dma_req
		&& (!master_trigger || $past(master_out_select_r) != BPUT_MOS_UPDATE))
		else $error("inhibited overflow produced an event");
	AST_REINIT: assert property (ce && reinit |=> count_r == '0)
		else $error("trigger did not clear the counter");
	AST_UPDATE_OUT: assert property (ce && ovf_evt && master_out_select_r == BPUT_MOS_UPDATE
		|=> master_trigger)
		else $error("update trigger missing");
	AST_DMA: assert property (ce && ovf_evt |=> dma_req == $past(overflow_dma_on_r))
		else $error("DMA request does not match its enable");
	AST_FLAG: assert property (ce && ovf_evt |=> overflow_flag_r)
		else $error("flag not set by overflow event");
	AST_SOFT_FLAG: assert property (ce && soft_trig && !overflow_inhibit_r && !overflow_source_sel_r
		|=> overflow_flag_r)
		else $error("software trigger did not set the flag");
	AST_SHADOW: assert property (ce && period_buffer_on_r && !ovf_evt |=> $stable(period_sh_r))
		else $error("buffered period changed outside an event");
	AST_WRAP: assert property (ce && cnt_ovf && !(wr_commit && hit(avs_address, `BPUT_OFS_COUNT_VALUE))
		|=> count_r == '0 && (overflow_flag_r || $past(overflow_inhibit_r)))
		else $error("counter did not wrap at period");
	AST_COUNT_VALUE_WR: assert property (ce && wr_commit && hit(avs_address, `BPUT_OFS_COUNT_VALUE) && !reinit
		|=> count_r == $past(avs_writedata[CNT_W-1:0]))
		else $error("counter write not applied");
	AST_IRQ: assert property (ce && overflow_flag_r && overflow_irq_on_r |=> irq)
		else $error("interrupt missing");
	AST_ANSWER: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest || !ce)
		else $error("waitrequest not low for exactly one cycle");
endmodule
`default_nettype wire
